// ===== verilog/tws_top.sv
// tws: two-wire slave-transmit end, bus error and start handling, apb slave
//
// Behaviour
// - nack after sent byte gives C0 and flag
// - ack after last byte gives C8
// - clearing flag in C0/C8 leaves slave unaddressed
// - ack_enable low: ignore own and general call
// - ack_enable high: own, general call if enabled
// - start_request: wait bus free, send start
// - flag clear reads status F8
// - misplaced start or stop reports code 00
// - bus error sets the done flag
// - recovery: unaddressed, stop_request self-clears only
// - recovery releases lines, sends no stop
// - direction change uses repeated start, not stop
// - after repeated start keep owning the bus
// - status in bits 7:3, prescale in 1:0
// - flag set stretches clock, except after bus error; only software clears
`include "tws_defs.svh"
`default_nettype none

// ---------------------------------------------------------------
// link side: pin sampling and condition detection on the link clock
// ---------------------------------------------------------------
module tws_link_mon (
   input wire logic LINK_CLK,
   input wire logic RST_N,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output tws_pkg::tws_ev_t TOG
);
   import tws_pkg::*;
   tws_link_t q;
   tws_link_t n;

   always_comb begin
      n = q;
      n.rst = {q.rst[0], RST_N};
      n.scl = {q.scl[0], SCL_I};
      n.sda = {q.sda[0], SDA_I};
      n.scl_p = q.scl[1];
      n.sda_p = q.sda[1];
      // each event flips a toggle so the system side sees it once
      if (q.scl_p && q.scl[1] && q.sda_p && !q.sda[1]) begin
         n.tog.start = ~q.tog.start;
      end
      if (q.scl_p && q.scl[1] && !q.sda_p && q.sda[1]) begin
         n.tog.stop = ~q.tog.stop;
      end
      if (!q.scl_p && q.scl[1]) begin
         n.tog.rise = ~q.tog.rise;
         n.tog.sda_r = q.sda[1];
      end
      if (q.scl_p && !q.scl[1]) begin
         n.tog.fall = ~q.tog.fall;
      end
      if (!q.rst[1]) begin
         n.scl_p = 1'b1;
         n.sda_p = 1'b1;
         n.tog = '0;
      end
   end

   always_ff @(posedge LINK_CLK) begin
      q <= n;
   end

   assign TOG = q.tog;
endmodule

// ---------------------------------------------------------------
// system side: registers, protocol engine, line drivers
// ---------------------------------------------------------------
module tws_top #(
   parameter logic [7:0] HOLD_CYC = 8'(`TWS_T_HOLD_CYC)
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic LINK_CLK,
   input wire tws_pkg::tws_addr_t PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire tws_pkg::tws_word_t PWDATA,
   output tws_pkg::tws_word_t PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SCL_O,
   output logic SDA_O,
   output logic SCL_OE,
   output logic SDA_OE
);
   import tws_pkg::*;
   tws_top_t q;
   tws_top_t n;
   tws_ev_t tog;
   tws_ev_t e;
   logic clr;
   logic berr;
   logic wr;
   logic set;
   logic [4:0] sc;
   logic hit_own;
   logic hit_gc;

   function automatic logic is_mapped(tws_addr_t a);
      is_mapped = a == `TWS_OFF_CTRL || a == `TWS_OFF_STAT ||
                  a == `TWS_OFF_DATA || a == `TWS_OFF_SADR;
   endfunction

   function automatic logic [7:0] stat_byte(logic done, logic [4:0] code,
                                            logic [1:0] ps);
      stat_byte = {done ? code : `TWS_SC_F8, 1'b0, ps};
   endfunction

   tws_link_mon u_link (
      .LINK_CLK(LINK_CLK),
      .RST_N(RST_N),
      .SCL_I(SCL_I),
      .SDA_I(SDA_I),
      .TOG(tog)
   );

   always_comb begin
      n = q;
      clr = 1'b0;
      set = 1'b0;
      sc = q.code;
      hit_own = 1'b0;
      hit_gc = 1'b0;
      // toggle synchroniser; the sampled data bit is taken from the same stage as the toggles
      n.ev1 = tog;
      n.ev2 = q.ev1;
      n.ev3 = q.ev2;
      n.ev4 = q.ev3;
      e = q.ev3 ^ q.ev4;
      e.sda_r = q.ev3.sda_r;

      // ------------------------------------------------------------
      // apb slave: one wait state, error on unmapped address
      // ------------------------------------------------------------
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (PSEL && PENABLE && !q.pready) begin
         n.pready = 1'b1;
         n.pslverr = !is_mapped(PADDR);
         n.prdata = '0;
         case (PADDR)
            `TWS_OFF_CTRL: begin
               n.prdata[`TWS_B_DONE] = q.op_done;
               n.prdata[`TWS_B_ACKEN] = q.ack_en;
               n.prdata[`TWS_B_STA] = q.sta_req;
               n.prdata[`TWS_B_STO] = q.sto_req;
            end
            `TWS_OFF_STAT: n.prdata[7:0] = stat_byte(q.op_done, q.code,
                                                     q.ps);
            `TWS_OFF_DATA: n.prdata[7:0] = q.data;
            `TWS_OFF_SADR: n.prdata[7:0] = {q.own_addr, q.gce};
            default: n.prdata = '0;
         endcase
      end
      wr = PSEL && PENABLE && q.pready && PWRITE && !q.pslverr;
      if (wr) begin
         case (PADDR)
            `TWS_OFF_CTRL: begin
               n.ack_en = PWDATA[`TWS_B_ACKEN];
               n.sta_req = PWDATA[`TWS_B_STA];
               n.sto_req = PWDATA[`TWS_B_STO];
               clr = PWDATA[`TWS_B_DONE] && q.op_done;
            end
            `TWS_OFF_STAT: n.ps = PWDATA[1:0];
            `TWS_OFF_DATA: n.data = PWDATA[7:0];
            `TWS_OFF_SADR: begin
               n.own_addr = PWDATA[7:1];
               n.gce = PWDATA[`TWS_B_GCE];
            end
            default: n.ps = q.ps;
         endcase
      end
      if (clr) begin
         n.op_done = 1'b0;
      end

      if (e.start) begin
         n.busy = 1'b1;
      end
      if (e.stop) begin
         n.busy = 1'b0;
      end

      // ------------------------------------------------------------
      // protocol engine
      // ------------------------------------------------------------
      berr = (e.start || e.stop) &&
             ((q.st == ST_ADDR && q.bcnt != 4'h0) || q.st == ST_AACK ||
              q.st == ST_TXB || q.st == ST_TACK);
      if (berr) begin
         n.st = ST_BERR;
         set = 1'b1;
         sc = `TWS_SC_BERR;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
      end else begin
         unique case (q.st)
            ST_IDLE: begin
               if (e.start) begin
                  n.st = ST_ADDR;
                  n.bcnt = '0;
               end else if (q.sta_req) begin
                  n.st = ST_MSTA;
                  n.tcnt = '0;
                  n.mph = '0;
               end
            end
            ST_ADDR: begin
               if (e.stop) begin
                  n.st = ST_IDLE;
               end else if (e.start) begin
                  n.bcnt = '0;
               end else if (e.rise) begin
                  n.sh = {q.sh[6:0], e.sda_r};
                  n.bcnt = q.bcnt + 4'h1;
               end else if (e.fall && q.bcnt == `TWS_BITS_BYTE) begin
                  hit_own = q.ack_en && q.sh[7:1] == q.own_addr;
                  hit_gc = q.ack_en && q.gce && q.sh[7:1] == 7'h00 &&
                           !q.sh[0];
                  if (hit_own || hit_gc) begin
                     n.st = ST_AACK;
                     n.sda_oe = 1'b1;
                     n.rd = q.sh[0];
                     n.gcall = hit_gc && !hit_own;
                  end else begin
                     n.st = ST_SKIP;
                  end
               end
            end
            ST_AACK: begin
               if (e.fall) begin
                  n.sda_oe = 1'b0;
                  n.scl_oe = 1'b1;
                  n.st = ST_HOLD;
                  set = 1'b1;
                  sc = q.rd ? `TWS_SC_A8 :
                       (q.gcall ? `TWS_SC_GCRX : `TWS_SC_SRX);
               end
            end
            ST_HOLD: begin
               n.scl_oe = 1'b1;
               if (clr) begin
                  n.scl_oe = 1'b0;
                  if (q.code == `TWS_SC_A8 || q.code == `TWS_SC_B8) begin
                     n.st = ST_TXB;
                     n.sh = q.data;
                     n.bcnt = '0;
                     n.sda_oe = !q.data[7];
                     n.last = !n.ack_en;
                  end else if (q.code == `TWS_SC_SRX ||
                               q.code == `TWS_SC_GCRX) begin
                     n.st = ST_SKIP;
                  end else if (n.sta_req) begin
                     n.st = ST_MSTA;
                     n.tcnt = '0;
                     n.mph = '0;
                  end else begin
                     n.st = ST_IDLE;
                  end
               end
            end
            ST_TXB: begin
               if (e.fall) begin
                  if (q.bcnt == `TWS_LAST_BIT) begin
                     n.sda_oe = 1'b0;
                     n.st = ST_TACK;
                  end else begin
                     n.sh = {q.sh[6:0], 1'b0};
                     n.bcnt = q.bcnt + 4'h1;
                     n.sda_oe = !q.sh[6];
                  end
               end
            end
            ST_TACK: begin
               if (e.rise) begin
                  n.sh[0] = e.sda_r;
               end else if (e.fall) begin
                  set = 1'b1;
                  n.st = ST_HOLD;
                  n.scl_oe = 1'b1;
                  if (q.sh[0]) begin
                     sc = `TWS_SC_C0;
                  end else if (q.last) begin
                     sc = `TWS_SC_C8;
                  end else begin
                     sc = `TWS_SC_B8;
                  end
               end
            end
            ST_SKIP: begin
               if (e.start) begin
                  n.st = ST_ADDR;
                  n.bcnt = '0;
               end else if (e.stop) begin
                  n.st = ST_IDLE;
               end
            end
            ST_BERR: begin
               // lines stay released, nothing is driven on the bus
               if (clr && n.sto_req) begin
                  n.st = ST_IDLE;
                  n.sto_req = 1'b0;
               end
            end
            ST_MSTA: begin
               // phase 0 waits for a free bus unless already owned
               if (q.mph != 2'h0 || !q.busy || q.own_bus) begin
                  n.tcnt = q.tcnt + 8'h01;
                  if (q.tcnt == HOLD_CYC) begin
                     n.tcnt = '0;
                     n.mph = q.mph + 2'h1;
                     if (q.mph == 2'h0) begin
                        n.sda_oe = 1'b1;
                     end else begin
                        n.scl_oe = 1'b1;
                        n.st = ST_MOWN;
                        set = 1'b1;
                        sc = q.own_bus ? `TWS_SC_RSTART : `TWS_SC_START;
                        n.own_bus = 1'b1;
                     end
                  end
               end
            end
            ST_MOWN: begin
               n.scl_oe = 1'b1;
               if (clr && n.sta_req) begin
                  n.st = ST_MSTA;
                  n.tcnt = '0;
                  n.mph = '0;
                  n.sda_oe = 1'b0;
                  n.scl_oe = 1'b0;
               end else if (clr && n.sto_req) begin
                  n.st = ST_MSTO;
                  n.tcnt = '0;
                  n.mph = '0;
                  n.sda_oe = 1'b1;
               end
            end
            ST_MSTO: begin
               n.tcnt = q.tcnt + 8'h01;
               if (q.tcnt == HOLD_CYC) begin
                  n.tcnt = '0;
                  n.mph = q.mph + 2'h1;
                  if (q.mph == 2'h0) begin
                     n.scl_oe = 1'b0;
                  end else begin
                     n.sda_oe = 1'b0;
                     n.sto_req = 1'b0;
                     n.own_bus = 1'b0;
                     n.st = ST_IDLE;
                  end
               end
            end
            default: n.st = ST_IDLE;
         endcase
      end
      // a hardware set wins over a clear in the same cycle
      if (set) begin
         n.op_done = 1'b1;
         n.code = sc;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         q <= '0;
      end else if (CE) begin
         q <= n;
      end
   end

   assign PRDATA = q.prdata;
   assign PREADY = q.pready;
   assign PSLVERR = q.pslverr;
   assign SCL_O = 1'b0;
   assign SDA_O = 1'b0;
   assign SCL_OE = q.scl_oe;
   assign SDA_OE = q.sda_oe;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_end_wait;
      q.st == ST_HOLD && (q.code == `TWS_SC_C0 || q.code == `TWS_SC_C8);
   endsequence
   sequence s_plain_clear;
      CE && clr && !berr && !n.sta_req;
   endsequence
   property p_end_leave;
      s_end_wait ##0 s_plain_clear |=> q.st == ST_IDLE && !q.op_done;
   endproperty

   chk_nack_code: assert property (
      CE && !berr && q.st == ST_TACK && e.fall && q.sh[0]
      |=> q.op_done && q.code == `TWS_SC_C0)
      else $error("nack after byte did not report C0");
   chk_last_ack: assert property (
      CE && !berr && q.st == ST_TACK && e.fall && !q.sh[0] && q.last
      |=> q.op_done && q.code == `TWS_SC_C8 && q.scl_oe)
      else $error("ack after last byte did not report C8");
   chk_end_leave: assert property (p_end_leave)
      else $error("clear in C0 or C8 did not go unaddressed");
   chk_addr_ignore: assert property (
      CE && !berr && q.st == ST_ADDR && e.fall && !e.start && !e.stop &&
      !e.rise && q.bcnt == `TWS_BITS_BYTE && !q.ack_en
      |=> q.st == ST_SKIP && !q.sda_oe)
      else $error("address taken while acknowledge disabled");
   chk_wait_free: assert property (
      CE && q.st == ST_MSTA && q.mph == 2'h0 && q.busy && !q.own_bus &&
      !e.stop |=> q.st == ST_MSTA && !q.sda_oe && q.tcnt == $past(q.tcnt))
      else $error("start sent while the bus was busy");
   chk_idle_f8: assert property (
      CE && !q.op_done && PSEL && PENABLE && !q.pready &&
      PADDR == `TWS_OFF_STAT |=> q.prdata[7:3] == `TWS_SC_F8)
      else $error("status not F8 while flag clear");
   chk_berr_code: assert property (
      CE && berr |=> q.op_done && q.code == `TWS_SC_BERR &&
      q.st == ST_BERR)
      else $error("bus error not reported as 00");
   chk_recover_ctl: assert property (
      CE && q.st == ST_BERR && clr && n.sto_req
      |=> q.st == ST_IDLE && !q.sto_req && q.ack_en == $past(n.ack_en) &&
      q.sta_req == $past(n.sta_req))
      else $error("bus error recovery wrong");
   chk_berr_release: assert property (
      q.st == ST_BERR |-> !q.scl_oe && !q.sda_oe)
      else $error("line driven during bus error");
   chk_keep_bus: assert property (
      q.st == ST_MOWN |-> q.own_bus && q.scl_oe)
      else $error("bus given up after start");
   chk_flag_hold: assert property (
      q.op_done && !clr && CE |=> q.op_done && q.code == $past(q.code))
      else $error("flag or code changed without clear");
   chk_stretch: assert property (
      q.st == ST_HOLD ##1 q.st == ST_HOLD |-> q.scl_oe)
      else $error("clock not stretched while flag set");
endmodule
`default_nettype wire

// ===== verilog/tws_defs.svh
// register offsets, field positions, status codes and timing of the tws block
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_OFF_CTRL 8'h00
`define TWS_OFF_STAT 8'h04
`define TWS_OFF_DATA 8'h08
`define TWS_OFF_SADR 8'h0c
`define TWS_B_DONE 7
`define TWS_B_ACKEN 6
`define TWS_B_STA 5
`define TWS_B_STO 4
`define TWS_B_GCE 0
`define TWS_SC_BERR 5'h00
`define TWS_SC_START 5'h01
`define TWS_SC_RSTART 5'h02
`define TWS_SC_SRX 5'h0c
`define TWS_SC_GCRX 5'h0e
`define TWS_SC_A8 5'h15
`define TWS_SC_B8 5'h17
`define TWS_SC_C0 5'h18
`define TWS_SC_C8 5'h19
`define TWS_SC_F8 5'h1f
`define TWS_BITS_BYTE 4'h8
`define TWS_LAST_BIT 4'h7
`define TWS_CLK_NS 8
`define TWS_T_HOLD_NS 600
`define TWS_T_HOLD_CYC ((`TWS_T_HOLD_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

// ===== verilog/tws_pkg.sv
// types shared by the tws two-wire end-of-transfer and bus-error block
`default_nettype none
package tws_pkg;
   typedef logic [7:0] tws_addr_t;
   typedef logic [31:0] tws_word_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_AACK = 4'h3,
      ST_HOLD = 4'h2,
      ST_TXB = 4'h6,
      ST_TACK = 4'h7,
      ST_SKIP = 4'h5,
      ST_BERR = 4'h4,
      ST_MSTA = 4'h8,
      ST_MOWN = 4'h9,
      ST_MSTO = 4'hb
   } tws_state_t;
   typedef struct packed {
      logic sda_r;
      logic fall;
      logic rise;
      logic stop;
      logic start;
   } tws_ev_t;
   typedef struct packed {
      logic [1:0] rst;
      logic [1:0] scl;
      logic [1:0] sda;
      logic scl_p;
      logic sda_p;
      tws_ev_t tog;
   } tws_link_t;
   typedef struct packed {
      tws_state_t st;
      logic op_done;
      logic ack_en;
      logic sta_req;
      logic sto_req;
      logic [6:0] own_addr;
      logic gce;
      logic [1:0] ps;
      logic [4:0] code;
      logic [7:0] data;
      logic [7:0] sh;
      logic [3:0] bcnt;
      logic rd;
      logic gcall;
      logic last;
      logic busy;
      logic own_bus;
      logic [7:0] tcnt;
      logic [1:0] mph;
      tws_ev_t ev1;
      tws_ev_t ev2;
      tws_ev_t ev3;
      tws_ev_t ev4;
      tws_word_t prdata;
      logic pready;
      logic pslverr;
      logic scl_oe;
      logic sda_oe;
   } tws_top_t;
endpackage
`default_nettype wire

// ===== sim/ise_bus_master.sv
// two-wire bus master model standing on the far side of the block
`default_nettype none
module ise_bus_master #(
   parameter int HALF = 20
) (
   input wire logic CLK,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SCL_PULL,
   output logic SDA_PULL
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      SCL_PULL = 1'b0;
      SDA_PULL = 1'b0;
   end
   task automatic tick(input int c);
      repeat (c) @(posedge CLK);
   endtask
   // release the clock, then wait while a slave stretches it low
   task automatic scl_up();
      int k;
      k = 0;
      SCL_PULL <= 1'b0;
      tick(1);
      while (SCL_I !== 1'b1 && k < 4000) begin
         tick(1);
         k++;
      end
      tick(HALF);
   endtask
   task automatic put_bit(input logic b);
      SDA_PULL <= !b;
      tick(HALF);
      scl_up();
      SCL_PULL <= 1'b1;
      tick(HALF);
   endtask
   task automatic get_bit(output logic b);
      SDA_PULL <= 1'b0;
      tick(HALF);
      scl_up();
      b = SDA_I;
      SCL_PULL <= 1'b1;
      tick(HALF);
   endtask
   task automatic start();
      SDA_PULL <= 1'b0;
      tick(HALF);
      scl_up();
      SDA_PULL <= 1'b1;
      tick(HALF);
      SCL_PULL <= 1'b1;
      tick(HALF);
   endtask
   // a stop also frees the bus for a pending start of the block
   task automatic stop();
      SDA_PULL <= 1'b1;
      tick(HALF);
      scl_up();
      SDA_PULL <= 1'b0;
      tick(HALF);
   endtask
   task automatic put_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--)
         put_bit(v[i]);
      get_bit(ack);
   endtask
   task automatic get_byte(output logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         get_bit(v[i]);
   endtask
endmodule
`default_nettype wire

// ===== sim/i2c_slave_tx_end_and_bus_error_bench.sv
// self-checking bench: slave transmit end, start handling and bus error
`include "tws_defs.svh"
`default_nettype none
module i2c_slave_tx_end_and_bus_error_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tws_pkg::*;
   localparam logic [6:0] own = 7'h3a;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic scl_o;
   logic sda_o;
   tws_addr_t paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   tws_word_t pwdata = 32'h0;
   tws_word_t prdata;
   logic pready;
   logic pslverr;
   logic scl_oe;
   logic sda_oe;
   logic m_scl;
   logic m_sda;
   int n_fail = 0;
   int cmp_count = 0;
   wire logic scl_w = !(m_scl | scl_oe);
   wire logic sda_w = !(m_sda | sda_oe);

   tws_top #(.HOLD_CYC(8'h04)) uut (
      .CLK(clk), .RST_N(rst_n), .CE(ce), .LINK_CLK(link_clk),
      .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SCL_I(scl_w), .SDA_I(sda_w), .SCL_O(scl_o),
      .SDA_O(sda_o), .SCL_OE(scl_oe), .SDA_OE(sda_oe)
   );
   ise_bus_master #(.HALF(20)) m (
      .CLK(clk), .SCL_I(scl_w), .SDA_I(sda_w),
      .SCL_PULL(m_scl), .SDA_PULL(m_sda)
   );

   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      #3;
      forever #7.5 link_clk = ~link_clk;
   end

   // ---------------------------------------------------------------
   // access and compare tasks
   // ---------------------------------------------------------------
   task automatic fail(input string msg);
      n_fail++;
      $display("FAIL %0t %s", $time, msg);
   endtask
   task automatic chk_word(input tws_word_t g, input tws_word_t e,
                           input string msg);
      cmp_count++;
      if (g !== e)
         fail($sformatf("%s got %h want %h", msg, g, e));
   endtask
   task automatic chk_bit(input logic g, input logic e, input string msg);
      cmp_count++;
      if (g !== e)
         fail(msg);
   endtask
   task automatic bus(input logic w, input tws_addr_t a, input tws_word_t d,
                      output tws_word_t r, output logic err);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
         fail("no bus answer");
   endtask
   task automatic wr(input tws_addr_t a, input tws_word_t d);
      tws_word_t r;
      logic e;
      bus(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input tws_addr_t a, input tws_word_t x,
                         input string msg);
      tws_word_t r;
      logic e;
      bus(1'b0, a, 32'h0, r, e);
      chk_word(r, x, msg);
   endtask
   // poll until the masked value leaves its waiting value, then compare
   task automatic wait_reg(input tws_addr_t a, input tws_word_t mask,
                           input tws_word_t hold, input tws_word_t x);
      tws_word_t r;
      logic e;
      int k;
      k = 0;
      do begin
         bus(1'b0, a, 32'h0, r, e);
         k++;
      end while ((r & mask) === hold && k < 300);
      chk_word(r, x, "register after wait");
   endtask
   task automatic wait_code(input tws_word_t x);
      wait_reg(`TWS_OFF_STAT, 32'hff, 32'hf8, x);
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      tws_word_t r;
      logic a;
      logic [7:0] b;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      settle(8);
      rd_chk(`TWS_OFF_STAT, 32'hf8, "idle status");
      rd_chk(`TWS_OFF_CTRL, 32'h0, "control reset");
      wr(`TWS_OFF_STAT, 32'h3);
      rd_chk(`TWS_OFF_STAT, 32'hfb, "prescale field");
      wr(`TWS_OFF_STAT, 32'h0);
      wr(`TWS_OFF_CTRL, 32'h80);
      rd_chk(`TWS_OFF_CTRL, 32'h0, "flag not set by write");
      bus(1'b0, 8'h10, 32'h0, r, a);
      chk_bit(a, 1'b1, "unmapped error");
      chk_word(r, 32'h0, "unmapped data");
      $display("test registers done");

      wr(`TWS_OFF_SADR, {24'h0, own, 1'b0});
      wr(`TWS_OFF_CTRL, 32'h40);
      m.start();
      m.put_byte({own, 1'b1}, a);
      chk_bit(a, 1'b0, "own address acked");
      wait_code(32'ha8);
      chk_bit(scl_oe, 1'b1, "clock stretched");
      wr(`TWS_OFF_DATA, 32'h5a);
      wr(`TWS_OFF_CTRL, 32'hc0);
      m.get_byte(b);
      chk_word({24'h0, b}, 32'h5a, "sent byte");
      m.put_bit(1'b1);
      wait_code(32'hc0);
      rd_chk(`TWS_OFF_STAT, 32'hc0, "code held");
      wr(`TWS_OFF_CTRL, 32'ha0);
      rd_chk(`TWS_OFF_CTRL, 32'h20, "flag cleared");
      settle(40);
      chk_bit(sda_oe, 1'b0, "no start on busy bus");
      m.start();
      m.put_byte({own, 1'b1}, a);
      chk_bit(a, 1'b1, "own address ignored");
      ce <= 1'b0;
      m.stop();
      settle(20);
      chk_bit(sda_oe, 1'b0, "frozen while disabled");
      ce <= 1'b1;
      wait_code(32'h08);
      chk_bit(sda_w, 1'b0, "start on data line");
      wr(`TWS_OFF_CTRL, 32'ha0);
      wait_code(32'h10);
      chk_bit(scl_oe, 1'b1, "bus kept");
      wr(`TWS_OFF_CTRL, 32'h90);
      wait_reg(`TWS_OFF_CTRL, 32'h10, 32'h10, 32'h0);
      settle(10);
      chk_bit(scl_w & sda_w, 1'b1, "bus free after stop");
      rd_chk(`TWS_OFF_STAT, 32'hf8, "no information");
      $display("test nack end and start done");

      wr(`TWS_OFF_CTRL, 32'h40);
      m.start();
      m.put_byte(8'h00, a);
      chk_bit(a, 1'b1, "general call ignored");
      m.stop();
      wr(`TWS_OFF_SADR, {24'h0, own, 1'b1});
      m.start();
      m.put_byte(8'h00, a);
      chk_bit(a, 1'b0, "general call acked");
      wait_code(32'h70);
      wr(`TWS_OFF_CTRL, 32'hc0);
      m.stop();
      m.start();
      m.put_byte({own, 1'b1}, a);
      wait_code(32'ha8);
      wr(`TWS_OFF_DATA, 32'hc3);
      wr(`TWS_OFF_CTRL, 32'h80);
      m.get_byte(b);
      chk_word({24'h0, b}, 32'hc3, "last byte");
      m.put_bit(1'b0);
      wait_code(32'hc8);
      wr(`TWS_OFF_CTRL, 32'h80);
      m.get_byte(b);
      chk_word({24'h0, b}, 32'hff, "unaddressed slave silent");
      m.put_bit(1'b1);
      m.stop();
      m.start();
      m.put_byte({own, 1'b1}, a);
      chk_bit(a, 1'b1, "own address ignored after c8");
      m.stop();
      chk_bit(scl_o | sda_o, 1'b0, "open drain data low");
      wr(`TWS_OFF_CTRL, 32'h40);
      $display("test ack end done");

      m.start();
      m.put_byte({own, 1'b1}, a);
      chk_bit(a, 1'b0, "address kept after c8");
      wait_code(32'ha8);
      wr(`TWS_OFF_DATA, 32'hff);
      wr(`TWS_OFF_CTRL, 32'hc0);
      m.get_bit(a);
      m.get_bit(a);
      m.stop();
      wait_code(32'h00);
      settle(10);
      chk_bit(scl_oe | sda_oe, 1'b0, "lines released");
      wr(`TWS_OFF_CTRL, 32'hd0);
      rd_chk(`TWS_OFF_CTRL, 32'h40, "recovery control");
      rd_chk(`TWS_OFF_STAT, 32'hf8, "recovered idle");
      chk_bit(scl_w & sda_w, 1'b1, "no stop driven");
      $display("test bus error done");
      wrap_up();
   end

   initial begin
      repeat (60000) @(posedge clk);
      fail("watchdog expired");
      wrap_up();
   end
endmodule
`default_nettype wire
